// ---- verilog/ctarf_top.sv ----
// top: APB slave, link control, cycle start paths and request filter hookup
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module ctarf_top
   import ctarf_pkg::*;
(
   // clock and reset
   input  logic              pclk,
   input  logic              presetn,
   // APB slave
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [11:0]       paddr,
   input  logic [31:0]       pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // external 8 kHz cycle clock pin
   input  logic              ext_cycle_clk,
   // received cycle start
   input  logic              cycle_start_rx_valid,
   input  logic [31:0]       cycle_start_rx_data,
   // transmitted cycle start
   output logic              cycle_start_tx_valid,
   output logic [31:0]       cycle_start_tx_data,
   // incoming request source check
   input  logic              request_valid,
   input  logic              request_for_filtered_context,
   input  ctarf_node_id_type request_source,
   input  logic [9:0]        local_bus_number,
   output logic              request_decided,
   output logic              request_accepted,
   output logic              request_covered
);

   //------------------------------------------------------------------------
   // state
   //------------------------------------------------------------------------
   typedef struct packed {
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
      logic [CTRL_WIDTH-1:0] control;
      logic [2:0]            ext_sync;
      logic                  tx_valid;
      logic [31:0]           tx_data;
   } ctarf_top_state_type;

   ctarf_top_state_type state;
   ctarf_top_state_type next_state;
   ctarf_apb_req_type   req;
   ctarf_reg_sel_type   setup_sel;
   ctarf_reg_sel_type   access_sel;
   ctarf_timer_type     timer;
   logic                cycle_wrap;
   logic [31:0]         filter;
   logic                access_write;
   logic                is_master;
   logic                ext_tick;

   //------------------------------------------------------------------------
   // address decode, shared by setup (read data) and access (write strobe)
   //------------------------------------------------------------------------
   function automatic ctarf_reg_sel_type ctarf_decode(input logic [11:0] addr);
      if (addr == OFFSET_CYCLE_TIMER) begin
         return SEL_TIMER;
      end else if (addr == OFFSET_LINK_CONTROL) begin
         return SEL_CONTROL;
      end else if (addr == OFFSET_FILTER_SET) begin
         return SEL_FILTER_SET;
      end else if (addr == OFFSET_FILTER_CLEAR) begin
         return SEL_FILTER_CLEAR;
      end else begin
         return SEL_NONE;
      end
   endfunction

   assign req          = '{psel: psel, penable: penable, pwrite: pwrite,
                           paddr: paddr, pwdata: pwdata};
   assign setup_sel    = ctarf_decode(req.paddr);
   assign access_sel   = setup_sel;
   // write lands on the single edge where the master sees pready high
   assign access_write = req.psel && req.penable && req.pwrite && state.pready;
   assign is_master    = state.control[CTRL_MASTER_BIT];
   // ext_sync[0] feeds only ext_sync[1]; the edge is taken one stage later
   assign ext_tick     = state.ext_sync[1] && !state.ext_sync[2];

   always_comb begin
      next_state = state;
      //---------------------------------------------------------------------
      // APB: fixed one wait-free access phase, answer prepared in setup
      //---------------------------------------------------------------------
      if (req.psel && !req.penable) begin
         next_state.pready  = 1'b1;
         next_state.pslverr = 1'b0;
         if (setup_sel == SEL_TIMER) begin
            next_state.prdata = timer;
         end else if (setup_sel == SEL_CONTROL) begin
            next_state.prdata = {{(32-CTRL_WIDTH){1'b0}}, state.control};
         end else if (setup_sel == SEL_FILTER_SET || setup_sel == SEL_FILTER_CLEAR) begin
            next_state.prdata = filter;
         end else begin
            next_state.prdata  = 32'h0000_0000;
            next_state.pslverr = 1'b1;
         end
      end else begin
         next_state.pready  = 1'b0;
         next_state.pslverr = 1'b0;
      end
      if (access_write && access_sel == SEL_CONTROL) begin
         next_state.control = req.pwdata[CTRL_WIDTH-1:0];
      end
      //---------------------------------------------------------------------
      // external cycle clock synchroniser
      //---------------------------------------------------------------------
      next_state.ext_sync = {state.ext_sync[1:0], ext_cycle_clk};
      //---------------------------------------------------------------------
      // cycle start transmit: value just after the offset wrap
      //---------------------------------------------------------------------
      next_state.tx_valid = cycle_wrap && is_master;
      if (cycle_wrap && is_master) begin
         next_state.tx_data = timer;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.prdata   <= 32'h0000_0000;
         state.pready   <= 1'b0;
         state.pslverr  <= 1'b0;
         state.control  <= CTRL_RESET;
         state.ext_sync <= 3'h0;
         state.tx_valid <= 1'b0;
         state.tx_data  <= 32'h0000_0000;
      end else begin
         state <= next_state;
      end
   end

   //------------------------------------------------------------------------
   // cycle timer
   //------------------------------------------------------------------------
   ctarf_cycle_timer u_cycle_timer (
      .pclk        (pclk),
      .presetn     (presetn),
      .run         (state.control[CTRL_RUN_BIT]),
      .ext_clk_sel (state.control[CTRL_EXT_CLK_BIT]),
      .ext_tick    (ext_tick),
      .sw_write    (access_write && access_sel == SEL_TIMER),
      .sw_value    (req.pwdata),
      .load_valid  (cycle_start_rx_valid && !is_master),
      .load_value  (ctarf_timer_type'(cycle_start_rx_data)),
      .timer       (timer),
      .cycle_wrap  (cycle_wrap)
   );

   //------------------------------------------------------------------------
   // request filter
   //------------------------------------------------------------------------
   ctarf_req_filter u_req_filter (
      .pclk        (pclk),
      .presetn     (presetn),
      .set_write   (access_write && access_sel == SEL_FILTER_SET),
      .clear_write (access_write && access_sel == SEL_FILTER_CLEAR),
      .wdata       (req.pwdata),
      .filter      (filter),
      .check_valid (request_valid && request_for_filtered_context),
      .source      (request_source),
      .local_bus   (local_bus_number),
      .decided     (request_decided),
      .accepted    (request_accepted),
      .covered     (request_covered)
   );

   assign prdata               = state.prdata;
   assign pready               = state.pready;
   assign pslverr              = state.pslverr;
   assign cycle_start_tx_valid = state.tx_valid;
   assign cycle_start_tx_data  = state.tx_data;

endmodule

// ---- verilog/ctarf_pkg.sv ----
// package: constants, register map and types for the cycle timer and request filter
//---------------------------------------------------------------------------
// Overview of operation
// - offset counts link clocks, wraps at 3072
// - cycle number advances on offset wrap, mod 8000
// - seconds advance on cycle wrap, modulo 128
// - cycle master sends timer in cycle start
// - non-master loads timer from received cycle start
// - timer free-runs when enabled without cycle starts
// - external 8 kHz tick clears the offset
// - timer is software read/write and hardware updated
// - check source of physical/request-context packets
// - cleared node bit: no ack, no queueing
// - remote buses accepted only when bit 31 set
// - bits 30..19 enable nodes 62..51
// - filter: set and clear addresses, readable, zero reset
//---------------------------------------------------------------------------
package ctarf_pkg;

   //------------------------------------------------------------------------
   // register map (byte addresses)
   //------------------------------------------------------------------------
   localparam logic [11:0] OFFSET_CYCLE_TIMER  = 12'h0F0;
   localparam logic [11:0] OFFSET_LINK_CONTROL = 12'h0F8;
   localparam logic [11:0] OFFSET_FILTER_SET   = 12'h100;
   localparam logic [11:0] OFFSET_FILTER_CLEAR = 12'h104;

   // link control fields
   localparam int          CTRL_MASTER_BIT   = 0;
   localparam int          CTRL_RUN_BIT      = 1;
   localparam int          CTRL_EXT_CLK_BIT  = 2;
   localparam int          CTRL_WIDTH        = 3;
   localparam logic [2:0]  CTRL_RESET        = 3'h0;

   // reset values
   localparam logic [31:0] TIMER_RESET       = 32'h0000_0000;
   localparam logic [31:0] FILTER_RESET      = 32'h0000_0000;

   //------------------------------------------------------------------------
   // cycle timer fields and moduli
   //------------------------------------------------------------------------
   localparam int          SECONDS_LSB       = 25;
   localparam int          CYCLE_LSB         = 12;
   localparam logic [11:0] OFFSET_LAST       = 12'hBFF;   // 3072 - 1
   localparam logic [12:0] CYCLE_LAST        = 13'h1F3F;  // 8000 - 1

   // fractional divider: link rate / bus clock rate, both in kHz
   localparam logic [16:0] BUS_CLOCK_KHZ     = 17'h186A0; // 100000
   localparam logic [16:0] LINK_CLOCK_KHZ    = 17'h06000; // 24576
   localparam logic [16:0] PHASE_WRAP_AT     = BUS_CLOCK_KHZ - LINK_CLOCK_KHZ;

   //------------------------------------------------------------------------
   // request filter fields
   //------------------------------------------------------------------------
   localparam int          ALL_BUSES_BIT     = 31;
   localparam logic [5:0]  NODE_FIRST        = 6'h33;     // node 51
   localparam logic [5:0]  NODE_LAST         = 6'h3E;     // node 62
   localparam logic [5:0]  NODE_BIT_BASE     = 6'h20;     // bit = node - 32
   localparam logic [9:0]  LOCAL_BUS_ALIAS   = 10'h3FF;
   localparam logic [31:0] FILTER_IMPL_MASK  = 32'hFFF8_0000;

   //------------------------------------------------------------------------
   // types
   //------------------------------------------------------------------------
   typedef struct packed {
      logic [6:0]  seconds_count;
      logic [12:0] cycle_number;
      logic [11:0] tick_offset;
   } ctarf_timer_type;

   typedef struct packed {
      logic [9:0] bus;
      logic [5:0] node;
   } ctarf_node_id_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ctarf_apb_req_type;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_TIMER,
      SEL_CONTROL,
      SEL_FILTER_SET,
      SEL_FILTER_CLEAR
   } ctarf_reg_sel_type;

   typedef struct packed {
      ctarf_timer_type timer;
      logic [16:0]     phase;
      logic            cycle_wrap;
   } ctarf_tmr_state_type;

   typedef struct packed {
      logic [31:0] filter;
      logic        decided;
      logic        accepted;
      logic        covered;
   } ctarf_flt_state_type;

endpackage

// ---- verilog/ctarf_cycle_timer.sv ----
// cycle timer: seconds / cycle number / offset counter with link-rate divider
`timescale 1ns/10ps
module ctarf_cycle_timer
   import ctarf_pkg::*;
(
   // clock and reset
   input  logic            pclk,
   input  logic            presetn,
   // control
   input  logic            run,
   input  logic            ext_clk_sel,
   input  logic            ext_tick,
   // software write and received load
   input  logic            sw_write,
   input  logic [31:0]     sw_value,
   input  logic            load_valid,
   input  ctarf_timer_type load_value,
   // state out
   output ctarf_timer_type timer,
   output logic            cycle_wrap
);

   ctarf_tmr_state_type state;
   ctarf_tmr_state_type next_state;
   logic                link_tick;

   //------------------------------------------------------------------------
   // offset reset plus cycle carry, shared by internal wrap and external tick
   //------------------------------------------------------------------------
   function automatic ctarf_timer_type ctarf_next_cycle(input ctarf_timer_type t);
      ctarf_timer_type r;
      r = t;
      r.tick_offset = '0;
      if (t.cycle_number >= CYCLE_LAST) begin
         r.cycle_number  = '0;
         r.seconds_count = t.seconds_count + 7'h01;
      end else begin
         r.cycle_number = t.cycle_number + 13'h0001;
      end
      return r;
   endfunction

   always_comb begin
      next_state            = state;
      next_state.cycle_wrap = 1'b0;
      link_tick             = 1'b0;
      // average rate of link_tick is exactly 24.576 MHz; jitter is one bus clock
      if (state.phase >= PHASE_WRAP_AT) begin
         next_state.phase = state.phase - PHASE_WRAP_AT;
         link_tick        = 1'b1;
      end else begin
         next_state.phase = state.phase + LINK_CLOCK_KHZ;
      end
      if (sw_write) begin
         next_state.timer = ctarf_timer_type'(sw_value);
      end else if (load_valid) begin
         next_state.timer = load_value;
      end else if (run) begin
         if (ext_clk_sel && ext_tick) begin
            next_state.timer      = ctarf_next_cycle(state.timer);
            next_state.cycle_wrap = 1'b1;
         end else if (link_tick) begin
            if (state.timer.tick_offset >= OFFSET_LAST) begin
               next_state.timer      = ctarf_next_cycle(state.timer);
               next_state.cycle_wrap = 1'b1;
            end else begin
               next_state.timer.tick_offset = state.timer.tick_offset + 12'h001;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.timer      <= TIMER_RESET;
         state.phase      <= '0;
         state.cycle_wrap <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign timer      = state.timer;
   assign cycle_wrap = state.cycle_wrap;

endmodule

// ---- verilog/ctarf_req_filter.sv ----
// asynchronous request filter, upper half: nodes 51..62 and remote buses
`timescale 1ns/10ps
module ctarf_req_filter
   import ctarf_pkg::*;
(
   // clock and reset
   input  logic              pclk,
   input  logic              presetn,
   // register access
   input  logic              set_write,
   input  logic              clear_write,
   input  logic [31:0]       wdata,
   output logic [31:0]       filter,
   // request check
   input  logic              check_valid,
   input  ctarf_node_id_type source,
   input  logic [9:0]        local_bus,
   output logic              decided,
   output logic              accepted,
   output logic              covered
);

   ctarf_flt_state_type state;
   ctarf_flt_state_type next_state;
   logic                is_local;
   logic [4:0]          bit_index;

   always_comb begin
      next_state = state;
      if (set_write) begin
         next_state.filter = state.filter | (wdata & FILTER_IMPL_MASK);
      end else if (clear_write) begin
         next_state.filter = state.filter & ~(wdata & FILTER_IMPL_MASK);
      end
      is_local  = (source.bus == LOCAL_BUS_ALIAS) || (source.bus == local_bus);
      bit_index = 5'(source.node - NODE_BIT_BASE);
      next_state.decided  = check_valid;
      next_state.accepted = 1'b0;
      next_state.covered  = 1'b0;
      if (check_valid) begin
         if (!is_local) begin
            next_state.covered  = 1'b1;
            next_state.accepted = state.filter[ALL_BUSES_BIT];
         end else if (source.node >= NODE_FIRST && source.node <= NODE_LAST) begin
            next_state.covered  = 1'b1;
            next_state.accepted = state.filter[bit_index];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state.filter   <= FILTER_RESET;
         state.decided  <= 1'b0;
         state.accepted <= 1'b0;
         state.covered  <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign filter   = state.filter;
   assign decided  = state.decided;
   assign accepted = state.accepted;
   assign covered  = state.covered;

endmodule

// ---- dv/ctarf_top_sva.sv ----
// checker: apb timing, cycle start and request decisions at the top ports
`timescale 1ns/10ps
module ctarf_top_sva
   import ctarf_pkg::*;
(
   // clock and reset
   input logic              pclk,
   input logic              presetn,
   // apb slave
   input logic              psel,
   input logic              penable,
   input logic [31:0]       prdata,
   input logic              pready,
   input logic              pslverr,
   // cycle start out
   input logic              cycle_start_tx_valid,
   input logic [31:0]       cycle_start_tx_data,
   // request check
   input logic              request_valid,
   input logic              request_for_filtered_context,
   input ctarf_node_id_type request_source,
   input logic [9:0]        local_bus_number,
   input logic              request_decided,
   input logic              request_accepted,
   input logic              request_covered
);
   //------------------------------------------------------------------------
   // properties
   //------------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic flt;
   logic on_local;
   logic in_window;
   assign flt       = request_valid && request_for_filtered_context;
   assign on_local  = request_source.bus == LOCAL_BUS_ALIAS ||
                      request_source.bus == local_bus_number;
   assign in_window = request_source.node >= NODE_FIRST && request_source.node <= NODE_LAST;

   chk_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   chk_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response without clean data");
   chk_decide_next: assert property (flt |=> request_decided)
      else $error("filtered request not decided");
   chk_decide_cause: assert property (request_decided |-> $past(flt))
      else $error("decision without filtered request");
   chk_refuse_uncovered: assert property (request_decided && !request_covered |-> !request_accepted)
      else $error("uncovered source accepted");
   chk_remote_covered: assert property (flt && !on_local |=> request_covered)
      else $error("remote bus source not covered");
   chk_node_window: assert property (flt && on_local |=> request_covered == $past(in_window))
      else $error("local node coverage wrong");
   chk_tx_offset_zero: assert property (cycle_start_tx_valid |-> cycle_start_tx_data[11:0] == 12'h000 ##1 !cycle_start_tx_valid)
      else $error("cycle start offset not zero");
   chk_tx_cycle_range: assert property (cycle_start_tx_valid |-> cycle_start_tx_data[24:12] <= CYCLE_LAST)
      else $error("cycle number beyond range");
endmodule

// ---- dv/ctarf_far_node.sv ----
// far-side node model: sends cycle start packets and request headers
`timescale 1ns/10ps
module ctarf_far_node
   import ctarf_pkg::*;
(
   // clock
   input  logic              pclk,
   // towards the block
   output logic              cycle_start_rx_valid,
   output logic [31:0]       cycle_start_rx_data,
   output logic              request_valid,
   output logic              request_for_filtered_context,
   output ctarf_node_id_type request_source
);
   initial begin
      cycle_start_rx_valid = 1'b0;
      cycle_start_rx_data = 32'h0;
      request_valid = 1'b0;
      request_for_filtered_context = 1'b0;
      request_source = '0;
   end
   // released lines show the inverse so stale data never passes for fresh
   task automatic send_cs(input logic [31:0] v);
      @(posedge pclk);
      cycle_start_rx_valid <= 1'b1;
      cycle_start_rx_data <= v;
      @(posedge pclk);
      cycle_start_rx_valid <= 1'b0;
      cycle_start_rx_data <= ~v;
   endtask
   task automatic send_req(input logic ctx, input ctarf_node_id_type s);
      @(posedge pclk);
      request_valid <= 1'b1;
      request_for_filtered_context <= ctx;
      request_source <= s;
      @(posedge pclk);
      request_valid <= 1'b0;
      request_for_filtered_context <= ~ctx;
      request_source <= ~s;
   endtask
endmodule

// ---- dv/ctarf_top_tb.sv ----
// testbench for the cycle timer and upper request filter block
`timescale 1ns/10ps
module ctarf_top_tb
   import ctarf_pkg::*;
;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, cycle_start_rx_data, cycle_start_tx_data;
   logic              ext_cycle_clk, cycle_start_rx_valid, cycle_start_tx_valid;
   logic              request_valid, request_for_filtered_context;
   ctarf_node_id_type request_source;
   logic [9:0]        local_bus_number;
   logic              request_decided, request_accepted, request_covered;
   int                n_fail, total_checks;

   ctarf_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ext_cycle_clk, .cycle_start_rx_valid, .cycle_start_rx_data,
      .cycle_start_tx_valid, .cycle_start_tx_data, .request_valid,
      .request_for_filtered_context, .request_source, .local_bus_number,
      .request_decided, .request_accepted, .request_covered);
   ctarf_far_node far_u (.pclk, .cycle_start_rx_valid, .cycle_start_rx_data,
      .request_valid, .request_for_filtered_context, .request_source);

   //------------------------------------------------------------------------
   // bus and check helpers
   //------------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // no own limit: only the watchdog may end a wait for pready
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk("pready_wait", 32'h1, 32'(n));
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(what, exp, q);
   endtask
   task automatic req(input logic ctx, input ctarf_node_id_type s, input logic cov, acc);
      far_u.send_req(ctx, s);
      #1;
      chk("decided", 32'(ctx), 32'(request_decided));
      if (ctx) begin
         chk("covered", 32'(cov), 32'(request_covered));
         chk("accepted", 32'(acc), 32'(request_accepted));
      end
   endtask

   //------------------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      rd(OFFSET_FILTER_SET, FILTER_RESET, "filter_reset");
      wr(OFFSET_FILTER_SET, 32'hFFFF_FFFF);
      rd(OFFSET_FILTER_CLEAR, FILTER_IMPL_MASK, "filter_all_set");
      wr(OFFSET_FILTER_CLEAR, 32'h4008_0000);
      wr(OFFSET_FILTER_SET, 32'h0000_0000);
      rd(OFFSET_FILTER_SET, 32'hBFF0_0000, "filter_cleared");
      apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, q, e);
      chk("unmapped_err", 32'h1, 32'(e));
      wr(OFFSET_CYCLE_TIMER, 32'h1234_5678);
      rd(OFFSET_CYCLE_TIMER, 32'h1234_5678, "timer_rw");
   endtask
   task automatic t_filter;
      logic [31:0] f;
      logic        cov;
      f = 32'hAAA8_0000;
      wr(OFFSET_FILTER_CLEAR, 32'hFFFF_FFFF);
      wr(OFFSET_FILTER_SET, 32'hAAAA_AAAA);
      rd(OFFSET_FILTER_SET, f, "filter_pattern");
      for (int b = 0; b < 2; b++) begin
         for (int n = 48; n < 64; n++) begin
            cov = n >= 51 && n <= 62;
            req(1'b1, {b ? local_bus_number : 10'h3FF, 6'(n)}, cov, cov && f[n - 32]);
         end
      end
      req(1'b1, {10'h001, 6'h05}, 1'b1, 1'b1);
      req(1'b0, {10'h3FF, 6'h34}, 1'b0, 1'b0);
      wr(OFFSET_FILTER_CLEAR, 32'h8000_0000);
      req(1'b1, {10'h001, 6'h05}, 1'b1, 1'b0);
   endtask
   task automatic t_rx_load;
      wr(OFFSET_LINK_CONTROL, 32'h0);
      far_u.send_cs(32'h0ABC_D123);
      rd(OFFSET_CYCLE_TIMER, 32'h0ABC_D123, "rx_loaded");
      wr(OFFSET_LINK_CONTROL, 32'h1);
      far_u.send_cs(32'h1111_1111);
      rd(OFFSET_CYCLE_TIMER, 32'h0ABC_D123, "rx_ignored_master");
   endtask
   task automatic t_rollover;
      logic [31:0] q;
      logic        e;
      wr(OFFSET_CYCLE_TIMER, 32'hFFF3_FBF0);
      wr(OFFSET_LINK_CONTROL, 32'h2);
      repeat (200) @(posedge pclk);
      apb(1'b0, OFFSET_CYCLE_TIMER, 32'h0, q, e);
      chk("seconds_cycle_wrap", 32'h0, 32'(q[31:12]));
      chk("offset_running", 32'h1, 32'(q[11:0] > 12'h000 && q[11:0] < 12'h040));
   endtask
   task automatic t_master_tx;
      int n;
      wr(OFFSET_LINK_CONTROL, 32'h1);
      wr(OFFSET_CYCLE_TIMER, 32'h0600_5BF0);
      wr(OFFSET_LINK_CONTROL, 32'h3);
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (cycle_start_tx_valid !== 1'b1 && n < 300);
      chk("tx_data", 32'h0600_6000, cycle_start_tx_data);
      chk("tx_time", 32'h1, 32'(n > 50 && n < 90));
   endtask
   task automatic t_ext;
      logic [31:0] q;
      logic        e;
      wr(OFFSET_LINK_CONTROL, 32'h6);
      rd(OFFSET_LINK_CONTROL, 32'h6, "control_rw");
      wr(OFFSET_CYCLE_TIMER, 32'h0000_7400);
      ext_cycle_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_cycle_clk <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, OFFSET_CYCLE_TIMER, 32'h0, q, e);
      chk("ext_cycle", 32'h8, 32'(q[24:12]));
      chk("ext_offset", 32'h1, 32'(q[11:0] < 12'h010));
   endtask

   task automatic finish_test;
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, ext_cycle_clk} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      local_bus_number = 10'h155;
      n_fail = 0;
      total_checks = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_filter;
      t_rx_load;
      t_rollover;
      t_master_tx;
      t_ext;
      finish_test;
   end
   // the whole run needs a few hundred cycles
   initial begin
      #100000;
      n_fail++;
      finish_test;
   end
endmodule

bind ctarf_top ctarf_top_sva chk_u (.pclk, .presetn, .psel, .penable, .prdata, .pready,
   .pslverr, .cycle_start_tx_valid, .cycle_start_tx_data, .request_valid,
   .request_for_filtered_context, .request_source, .local_bus_number, .request_decided,
   .request_accepted, .request_covered);
